// [rtl/pmsr_pkg.sv]
// Constants for the model-specific configuration register bank
package pmsr_pkg;

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 64;

    // ------------------------------------------------------------
    // Register indexes
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_LEGACY_MC_ADDRESS   = 12'h000;
    localparam logic [11:0] OFS_LEGACY_MC_TYPE      = 12'h001;
    localparam logic [11:0] OFS_CYCLE_STAMP_COUNTER = 12'h010;
    localparam logic [11:0] OFS_PLATFORM_IDENTITY   = 12'h017;
    localparam logic [11:0] OFS_LOCAL_INTC_BASE     = 12'h01B;
    localparam logic [11:0] OFS_HARD_POWERON_CONFIG = 12'h02A;
    localparam logic [11:0] OFS_TRACE_STORE_AREA    = 12'h600;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int TRACE_ADDR_MSB = 31;
    localparam int PLAT_FLAG_LSB  = 50;
    localparam int PLAT_FLAG_W    = 3;
    localparam int L2_LAT_LSB     = 53;
    localparam int L2_LAT_W       = 4;
    localparam int CLK_RATIO_BIT  = 60;
    localparam int BOOT_PROC_BIT  = 8;
    localparam int INTC_EN_BIT    = 11;
    localparam int INTC_BASE_LSB  = 12;
    localparam int INTC_BASE_W    = 20;
    localparam int DATA_ERR_BIT   = 1;

    // Strap bundle: ratio, latency, platform flag, boot processor
    localparam int STRAP_W = 1 + L2_LAT_W + PLAT_FLAG_W + 1;

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic [31:0] RST_TRACE_ADDR = 32'h0000_0000;
    localparam logic        RST_INTC_EN    = 1'b1;
    localparam logic [19:0] RST_INTC_BASE  = 20'h0_0000;
    localparam logic        RST_DATA_ERR   = 1'b0;
    localparam logic [63:0] RST_STAMP      = 64'h0000_0000_0000_0000;
    localparam logic [63:0] LEGACY_MC_VAL  = 64'h0000_0000_0000_0000;

    // Edges after reset release before straps are latched
    localparam logic [1:0]  STRAP_SETTLE   = 2'h3;

endpackage

// [rtl/pmsr_strap_cap.sv]
// Strap pin synchroniser that latches the levels once after reset
`timescale 1ns/10ps
module pmsr_strap_cap #(
    parameter int W = 9
) (
    input  wire logic         sys_clk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] strap_pin,
    output logic      [W-1:0] strap_val,
    output logic              strap_ok
);
    logic [W-1:0] sync1;
    logic [W-1:0] sync2;
    logic [1:0]   settle;

    // ------------------------------------------------------------
    // Two-stage synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= strap_pin;
            sync2 <= sync1;
        end
    end

    // Latch once the synchroniser has filled, then never again
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            settle    <= 2'h0;
            strap_val <= '0;
            strap_ok  <= 1'b0;
        end else if (!strap_ok) begin
            settle <= settle + 2'h1;
            if (settle == pmsr_pkg::STRAP_SETTLE - 2'h1) begin
                strap_val <= sync2;
                strap_ok  <= 1'b1;
            end
        end
    end

endmodule

// [rtl/pmsr_stamp_ctr.sv]
// Free-running cycle stamp counter with software load
`timescale 1ns/10ps
module pmsr_stamp_ctr #(
    parameter int W = 64
) (
    input  wire logic         sys_clk,
    input  wire logic         resetn,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    output logic      [W-1:0] count
);
    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            count <= pmsr_pkg::RST_STAMP[W-1:0];
        end else if (load) begin
            count <= load_val;
        end else begin
            count <= count + {{(W-1){1'b0}}, 1'b1};
        end
    end

endmodule

// [rtl/pmsr_regs.sv]
// Model-specific configuration and identification register bank
`timescale 1ns/10ps
module pmsr_regs (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic [11:0] reg_addr,
    input  wire logic [63:0] wr_data,
    input  wire logic        wr_stb,
    input  wire logic        rd_stb,
    input  wire logic [2:0]  plat_flag_pin,
    input  wire logic [3:0]  l2_latency_pin,
    input  wire logic        clk_ratio_pin,
    input  wire logic        boot_proc_pin,
    output logic      [63:0] rd_data,
    output logic             rd_err,
    output logic      [31:0] trace_area_addr,
    output logic             intc_global_en,
    output logic      [19:0] intc_base_addr,
    output logic             boot_processor_flag,
    output logic             data_err_chk_en,
    output logic      [63:0] cycle_stamp
);
    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic        hit_mca;
    logic        hit_mct;
    logic        hit_stamp;
    logic        hit_plat;
    logic        hit_intc;
    logic        hit_cfg;
    logic        hit_trace;
    logic        hit_any;
    logic [63:0] next_rd_data;
    logic [31:0] wr_low;

    always_comb begin
        hit_mca   = 1'b0;
        hit_mct   = 1'b0;
        hit_stamp = 1'b0;
        hit_plat  = 1'b0;
        hit_intc  = 1'b0;
        hit_cfg   = 1'b0;
        hit_trace = 1'b0;
        if (reg_addr == pmsr_pkg::OFS_LEGACY_MC_ADDRESS) begin
            hit_mca = 1'b1;
        end else if (reg_addr == pmsr_pkg::OFS_LEGACY_MC_TYPE) begin
            hit_mct = 1'b1;
        end else if (reg_addr == pmsr_pkg::OFS_CYCLE_STAMP_COUNTER) begin
            hit_stamp = 1'b1;
        end else if (reg_addr == pmsr_pkg::OFS_PLATFORM_IDENTITY) begin
            hit_plat = 1'b1;
        end else if (reg_addr == pmsr_pkg::OFS_LOCAL_INTC_BASE) begin
            hit_intc = 1'b1;
        end else if (reg_addr == pmsr_pkg::OFS_HARD_POWERON_CONFIG) begin
            hit_cfg = 1'b1;
        end else if (reg_addr == pmsr_pkg::OFS_TRACE_STORE_AREA) begin
            hit_trace = 1'b1;
        end
    end

    assign hit_any = hit_mca | hit_mct | hit_stamp | hit_plat
                   | hit_intc | hit_cfg | hit_trace;
    assign wr_low  = wr_data[31:0];

    // ------------------------------------------------------------
    // Strap capture and cycle stamp counter
    // ------------------------------------------------------------
    logic [pmsr_pkg::STRAP_W-1:0] strap_val;
    logic                         strap_ok;
    logic [2:0]                   plat_flag;
    logic [3:0]                   l2_latency;
    logic                         clk_ratio;

    pmsr_strap_cap #(
        .W (pmsr_pkg::STRAP_W)
    ) u_strap (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .strap_pin ({clk_ratio_pin, l2_latency_pin, plat_flag_pin, boot_proc_pin}),
        .strap_val (strap_val),
        .strap_ok  (strap_ok)
    );

    // Identity fields come from pins only; the bus has no path to them
    assign plat_flag  = strap_val[3:1];
    assign l2_latency = strap_val[7:4];
    assign clk_ratio  = strap_val[8];

    pmsr_stamp_ctr #(
        .W (pmsr_pkg::DATA_W)
    ) u_stamp (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .load     (wr_stb & hit_stamp),
        .load_val (wr_data),
        .count    (cycle_stamp)
    );

    // ------------------------------------------------------------
    // Trace store area pointer
    // ------------------------------------------------------------
    // Upper half is reserved, so only the low word is stored
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            trace_area_addr <= pmsr_pkg::RST_TRACE_ADDR;
        end else if (wr_stb && hit_trace) begin
            trace_area_addr <= wr_low;
        end
    end

    // ------------------------------------------------------------
    // Local interrupt controller base
    // ------------------------------------------------------------
    // Once cleared, the enable stays off until reset: re-enabling
    // without a reset would leave controller state half-initialised
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            intc_global_en <= pmsr_pkg::RST_INTC_EN;
            intc_base_addr <= pmsr_pkg::RST_INTC_BASE;
        end else if (wr_stb && hit_intc) begin
            intc_global_en <= intc_global_en & wr_data[pmsr_pkg::INTC_EN_BIT];
            intc_base_addr <= wr_data[pmsr_pkg::INTC_BASE_LSB +: pmsr_pkg::INTC_BASE_W];
        end
    end

    // Boot processor indicator follows the latched strap
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            boot_processor_flag <= 1'b0;
        end else if (strap_ok) begin
            boot_processor_flag <= strap_val[0];
        end
    end

    // ------------------------------------------------------------
    // Hard power-on configuration
    // ------------------------------------------------------------
    // Only bit 1 is writable here; every other bit of the word is
    // dropped so stray writes cannot reach feature logic
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            data_err_chk_en <= pmsr_pkg::RST_DATA_ERR;
        end else if (wr_stb && hit_cfg) begin
            data_err_chk_en <= wr_data[pmsr_pkg::DATA_ERR_BIT];
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb begin
        next_rd_data = 64'h0000_0000_0000_0000;
        if (hit_mca) begin
            next_rd_data = pmsr_pkg::LEGACY_MC_VAL;
        end else if (hit_mct) begin
            next_rd_data = pmsr_pkg::LEGACY_MC_VAL;
        end else if (hit_stamp) begin
            next_rd_data = cycle_stamp;
        end else if (hit_plat) begin
            next_rd_data[pmsr_pkg::PLAT_FLAG_LSB +: pmsr_pkg::PLAT_FLAG_W] = plat_flag;
            next_rd_data[pmsr_pkg::L2_LAT_LSB +: pmsr_pkg::L2_LAT_W] = l2_latency;
            next_rd_data[pmsr_pkg::CLK_RATIO_BIT] = clk_ratio;
        end else if (hit_intc) begin
            next_rd_data[pmsr_pkg::BOOT_PROC_BIT] = boot_processor_flag;
            next_rd_data[pmsr_pkg::INTC_EN_BIT] = intc_global_en;
            next_rd_data[pmsr_pkg::INTC_BASE_LSB +: pmsr_pkg::INTC_BASE_W] = intc_base_addr;
        end else if (hit_cfg) begin
            next_rd_data[pmsr_pkg::DATA_ERR_BIT] = data_err_chk_en;
        end else if (hit_trace) begin
            next_rd_data[pmsr_pkg::TRACE_ADDR_MSB:0] = trace_area_addr;
        end
    end

    // Read data stands for exactly one cycle, zero otherwise
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rd_data <= 64'h0000_0000_0000_0000;
        end else if (rd_stb) begin
            rd_data <= next_rd_data;
        end else begin
            rd_data <= 64'h0000_0000_0000_0000;
        end
    end

    // Unmapped access of either kind is flagged in the following cycle
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rd_err <= 1'b0;
        end else begin
            rd_err <= (rd_stb | wr_stb) & ~hit_any;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    sequence s_wr_plat;
        wr_stb && hit_plat;
    endsequence

    sequence s_rd_plat;
        rd_stb && hit_plat;
    endsequence

    sequence s_rd_intc;
        rd_stb && hit_intc;
    endsequence

    sequence s_rd_trace;
        rd_stb && hit_trace;
    endsequence

    sequence s_bad_access;
        (rd_stb || wr_stb) && !hit_any;
    endsequence

    a_trace_write_load: assert property (
        wr_stb && hit_trace |=> trace_area_addr == $past(wr_low))
        else $error("trace pointer did not take written address");

    a_trace_upper_zero: assert property (
        s_rd_trace |=> rd_data[63:32] == 32'h0000_0000
                       && rd_data[31:0] == trace_area_addr)
        else $error("trace pointer read back wrong");

    a_plat_write_ignored: assert property (
        s_wr_plat ##2 s_rd_plat |=> rd_data[63:50] ==
            {3'h0, clk_ratio, 3'h0, l2_latency, plat_flag})
        else $error("platform identity changed by a write");

    a_plat_flag_read: assert property (
        s_rd_plat |=> rd_data[52:50] == plat_flag)
        else $error("platform flag field wrong");

    a_l2_latency_read: assert property (
        s_rd_plat |=> rd_data[56:53] == l2_latency)
        else $error("cache latency field wrong");

    a_ratio_bit_read: assert property (
        s_rd_plat |=> rd_data[60] == clk_ratio && rd_data[49:0] == 50'h0)
        else $error("clock ratio or reserved field wrong");

    a_boot_flag_read: assert property (
        s_rd_intc |=> rd_data[8] == $past(boot_processor_flag) && rd_data[7:0] == 8'h00)
        else $error("boot processor bit wrong");

    a_intc_disable_sticky: assert property (
        !intc_global_en |=> !intc_global_en [*2])
        else $error("controller re-enabled without reset");

    a_data_err_write: assert property (
        wr_stb && hit_cfg |=> data_err_chk_en == $past(wr_data[1]))
        else $error("data error enable not written");

    a_data_err_read: assert property (
        rd_stb && hit_cfg |=> rd_data[1] == $past(data_err_chk_en))
        else $error("data error enable not read back");

    a_cfg_readonly_zero: assert property (
        rd_stb && hit_cfg |=> rd_data[63:2] == 62'h0 && rd_data[0] == 1'b0)
        else $error("configuration reserved bits not zero");

    a_read_one_cycle: assert property (
        !rd_stb |=> rd_data == 64'h0000_0000_0000_0000)
        else $error("read data stood beyond its cycle");

    a_bad_access_flag: assert property (
        s_bad_access |=> rd_err)
        else $error("unmapped access not flagged");

    a_err_flag_quiet: assert property (
        !rd_stb && !wr_stb |=> !rd_err)
        else $error("error flag raised without an access");

    a_unmapped_read_zero: assert property (
        rd_stb && !hit_any |=> rd_data == 64'h0000_0000_0000_0000)
        else $error("unmapped read returned data");

    a_legacy_mc_zero: assert property (
        rd_stb && (hit_mca || hit_mct) |=> rd_data == 64'h0000_0000_0000_0000)
        else $error("legacy machine-check word not zero");

    a_intc_base_write: assert property (
        wr_stb && hit_intc |=> intc_base_addr == $past(wr_data[31:12]))
        else $error("controller base not written");

    a_intc_read_back: assert property (
        s_rd_intc |=> rd_data[31:9] == {$past(intc_base_addr), $past(intc_global_en), 2'h0}
                      && rd_data[63:32] == 32'h0000_0000)
        else $error("controller base word read back wrong");

    a_strap_latch_once: assert property (
        strap_ok |=> strap_ok && $stable(strap_val))
        else $error("latched straps changed after capture");

    a_trace_no_stray: assert property (
        wr_stb && !hit_trace |=> $stable(trace_area_addr))
        else $error("trace pointer changed by another write");

    a_cfg_no_stray: assert property (
        wr_stb && !hit_cfg |=> $stable(data_err_chk_en))
        else $error("data error enable changed by another write");

endmodule

// [test/tb.sv]
// Self-checking testbench for the configuration register bank
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        sys_clk;
    logic        resetn;
    logic [11:0] reg_addr;
    logic [63:0] wr_data;
    logic        wr_stb;
    logic        rd_stb;
    logic [2:0]  plat_flag_pin;
    logic [3:0]  l2_latency_pin;
    logic        clk_ratio_pin;
    logic        boot_proc_pin;
    logic [63:0] rd_data;
    logic        rd_err;
    logic [31:0] trace_area_addr;
    logic        intc_global_en;
    logic [19:0] intc_base_addr;
    logic        boot_processor_flag;
    logic        data_err_chk_en;
    logic [63:0] cycle_stamp;
    int          errors;
    int          cmp_count;
    logic [63:0] d;
    logic        e;

    pmsr_regs i_dut (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
        .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .plat_flag_pin(plat_flag_pin),
        .l2_latency_pin(l2_latency_pin), .clk_ratio_pin(clk_ratio_pin),
        .boot_proc_pin(boot_proc_pin), .rd_data(rd_data), .rd_err(rd_err),
        .trace_area_addr(trace_area_addr), .intc_global_en(intc_global_en),
        .intc_base_addr(intc_base_addr), .boot_processor_flag(boot_processor_flag),
        .data_err_chk_en(data_err_chk_en), .cycle_stamp(cycle_stamp));

    always #50 sys_clk = ~sys_clk;

    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    // One idle edge before each strobe keeps a strobe from being set and cleared at once
    task automatic wr(input logic [11:0] a, input logic [63:0] v);
        @(posedge sys_clk);
        wr_stb   <= 1'b1;
        reg_addr <= a;
        wr_data  <= v;
        @(posedge sys_clk);
        wr_stb   <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [11:0] a, output logic [63:0] v, output logic err);
        @(posedge sys_clk);
        rd_stb   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        rd_stb   <= 1'b0;
        #1;
        v   = rd_data;
        err = rd_err;
    endtask

    // Straps are only latched after a reset, so each strap setting needs its own reset
    task automatic do_reset(input logic [2:0] f, input logic [3:0] l, input logic r,
                            input logic b);
        @(posedge sys_clk);
        resetn         <= 1'b0;
        plat_flag_pin  <= f;
        l2_latency_pin <= l;
        clk_ratio_pin  <= r;
        boot_proc_pin  <= b;
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (5) @(posedge sys_clk);
        #1;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_values();
        `CHK(intc_global_en, 1'b1)
        `CHK(data_err_chk_en, 1'b0)
        rd(pmsr_pkg::OFS_HARD_POWERON_CONFIG, d, e);
        `CHK(d, 64'h0000_0000_0000_0000)
        $display("done: reset values");
    endtask

    task automatic t_platform();
        logic [63:0] exp_p;
        for (int i = 0; i < 8; i++) begin
            do_reset(3'(i), 4'(15 - i), i[0], i[1]);
            exp_p = (64'(i) << pmsr_pkg::PLAT_FLAG_LSB)
                  | (64'(15 - i) << pmsr_pkg::L2_LAT_LSB)
                  | (64'(i[0]) << pmsr_pkg::CLK_RATIO_BIT);
            rd(pmsr_pkg::OFS_PLATFORM_IDENTITY, d, e);
            `CHK(d, exp_p)
            wr(pmsr_pkg::OFS_PLATFORM_IDENTITY, 64'hFFFF_FFFF_FFFF_FFFF);
            rd(pmsr_pkg::OFS_PLATFORM_IDENTITY, d, e);
            `CHK(d, exp_p)
            `CHK(e, 1'b0)
            rd(pmsr_pkg::OFS_LOCAL_INTC_BASE, d, e);
            `CHK(d, {55'h0, i[1], 8'h00} | 64'h800)
            `CHK(boot_processor_flag, i[1])
        end
        $display("done: platform identity");
    endtask

    task automatic t_trace();
        wr(pmsr_pkg::OFS_TRACE_STORE_AREA, 64'hA5A5_A5A5_1234_5678);
        `CHK(trace_area_addr, 32'h1234_5678)
        rd(pmsr_pkg::OFS_TRACE_STORE_AREA, d, e);
        `CHK(d, 64'h0000_0000_1234_5678)
        $display("done: trace pointer");
    endtask

    task automatic t_intc();
        wr(pmsr_pkg::OFS_LOCAL_INTC_BASE, 64'hFFFF_FFFF_FFFF_FEFF);
        rd(pmsr_pkg::OFS_LOCAL_INTC_BASE, d, e);
        `CHK(d, {32'h0, 20'hF_FFFF, 1'b1, 2'b00, boot_proc_pin, 8'h00})
        wr(pmsr_pkg::OFS_LOCAL_INTC_BASE, 64'h0000_0000_1234_5000);
        `CHK(intc_global_en, 1'b0)
        `CHK(intc_base_addr, 20'h1_2345)
        wr(pmsr_pkg::OFS_LOCAL_INTC_BASE, 64'h0000_0000_0ABC_D800);
        rd(pmsr_pkg::OFS_LOCAL_INTC_BASE, d, e);
        `CHK(d[11], 1'b0)
        `CHK(intc_base_addr, 20'h0_ABCD)
        $display("done: interrupt controller base");
    endtask

    task automatic t_config();
        wr(pmsr_pkg::OFS_HARD_POWERON_CONFIG, 64'hFFFF_FFFF_FFFF_FFFF);
        `CHK(data_err_chk_en, 1'b1)
        rd(pmsr_pkg::OFS_HARD_POWERON_CONFIG, d, e);
        `CHK(d, 64'h0000_0000_0000_0002)
        wr(pmsr_pkg::OFS_HARD_POWERON_CONFIG, 64'h0000_0000_0000_0000);
        `CHK(data_err_chk_en, 1'b0)
        $display("done: power-on config");
    endtask

    task automatic t_unmapped();
        rd(12'h7FF, d, e);
        `CHK(d, 64'h0000_0000_0000_0000)
        `CHK(e, 1'b1)
        @(posedge sys_clk);
        #1;
        `CHK(rd_err, 1'b0)
        rd(pmsr_pkg::OFS_LEGACY_MC_TYPE, d, e);
        `CHK(d, 64'h0000_0000_0000_0000)
        `CHK(e, 1'b0)
        $display("done: unmapped index");
    endtask

    task automatic t_stamp();
        wr(pmsr_pkg::OFS_CYCLE_STAMP_COUNTER, 64'h0123_4567_89AB_CDEF);
        `CHK(cycle_stamp, 64'h0123_4567_89AB_CDEF)
        @(posedge sys_clk);
        #1;
        `CHK(cycle_stamp, 64'h0123_4567_89AB_CDF0)
        $display("done: cycle stamp");
    endtask

    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        sys_clk        = 1'b0;
        resetn         = 1'b0;
        reg_addr       = 12'h000;
        wr_data        = 64'h0;
        wr_stb         = 1'b0;
        rd_stb         = 1'b0;
        plat_flag_pin  = 3'h5;
        l2_latency_pin = 4'h9;
        clk_ratio_pin  = 1'b1;
        boot_proc_pin  = 1'b1;
        errors         = 0;
        cmp_count      = 0;
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (5) @(posedge sys_clk);
        #1;
        t_reset_values();
        t_trace();
        t_config();
        t_unmapped();
        t_stamp();
        t_platform();
        t_intc();
        tally_and_finish();
    end

    // The tests need well under 1000 cycles; a hang is cut off at 5000
    initial begin
        #(5000 * 100);
        errors++;
        tally_and_finish();
    end
endmodule
